// *** hw/trib_ingress_cfg.svh ***
// Functional notes
// - indicator high exactly on C1/J0 byte cycle
// - indicator also high on each J1 byte
// - indicator low on all other cycles
// - bus disabled: indicator pin becomes line clock
// - line clock captures positive and negative rails
// - line clock times the ingress line-rail capture and the line bit counter
// - parity even or odd over data byte
// - parity may also cover both indicators
// - control byte selects parity sense and coverage
// - bus disabled: parity pin is positive rail
// - single rail carries whole stream on positive
// - dual rail: positive part on positive rail
// - line clock fed from recovered clock output
// - bus inputs sampled on bus clock fall
// - payload indicator low on overhead bytes only
// - dual rail: negative part on negative rail
`ifndef TRIB_INGRESS_CFG_SVH
`define TRIB_INGRESS_CFG_SVH
`define ICB0_OFFSET 12'h13B
`define ICB0_RESET 8'h00
`define ICB0_ODD_BIT 0
`define ICB0_COVER_IND_BIT 1
`define ICB0_BUS_EN_BIT 2
`define ICB0_LINE_FALL_BIT 3
`define ICB0_DUAL_RAIL_BIT 4
`define PORT_STATUS_OFFSET 12'h13C
`define FRAME_ROW_BYTES 16'h0870
`define LINE_CLK_DIV 8'h04
`endif

// *** hw/trib_ingress_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface trib_ingress_if;
   logic tx_bus_clock;
   logic [7:0] tx_bus_byte_in;
   logic tx_bus_payload_ind;
   logic tx_bus_frame_phase_ind;
   logic tx_bus_parity_in;
   logic rx_line_neg_data;
   modport device
   (
      input tx_bus_clock,
      input tx_bus_byte_in,
      input tx_bus_payload_ind,
      input tx_bus_frame_phase_ind,
      input tx_bus_parity_in,
      input rx_line_neg_data
   );
   modport source
   (
      output tx_bus_clock,
      output tx_bus_byte_in,
      output tx_bus_payload_ind,
      output tx_bus_frame_phase_ind,
      output tx_bus_parity_in,
      output rx_line_neg_data
   );
endinterface : trib_ingress_if
`default_nettype wire

// *** hw/trib_ingress_pkg.sv ***
package trib_ingress_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [2:0]
   {
      src_idle = 3'b001,
      src_bus = 3'b010,
      src_line = 3'b100
   } src_state_e;
endpackage : trib_ingress_pkg

// *** hw/trib_ingress_port.sv ***
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "trib_ingress_cfg.svh"
module trib_ingress_port
(
   input wire logic ref_clk,
   input wire logic rst_n,
   trib_ingress_if.device link,
   input wire logic [11:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   output logic [7:0] rx_byte,
   output logic rx_byte_valid,
   output logic rx_frame_phase,
   output logic rx_payload,
   output logic parity_error,
   output logic [1:0] rx_line_bits,
   output logic rx_line_valid
);
   logic [7:0] icb0_reg;
   logic [12:0] s1_reg;
   logic [12:0] s2_reg;
   logic clk_d_reg;
   logic parity_err_sticky_reg;
   logic [7:0] line_bit_cnt_reg;
   logic exp_par;
   logic bus_en;
   logic take_bus;
   logic take_line;

   // software control byte
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         icb0_reg <= `ICB0_RESET;
      else if (wr_en && addr == `ICB0_OFFSET)
         icb0_reg <= wr_data;
   end

   assign bus_en = icb0_reg[`ICB0_BUS_EN_BIT];

   // all pins cross into ref_clk; only the second stage is read
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         s1_reg <= 13'h0000;
         s2_reg <= 13'h0000;
      end
      else
      begin
         s1_reg <= {link.rx_line_neg_data, link.tx_bus_parity_in,
            link.tx_bus_frame_phase_ind, link.tx_bus_payload_ind,
            link.tx_bus_byte_in, link.tx_bus_clock};
         s2_reg <= s1_reg;
      end
   end

   // edge history of whichever pin acts as clock
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         clk_d_reg <= 1'b0;
      else if (bus_en)
         clk_d_reg <= s2_reg[0];
      else
         clk_d_reg <= s2_reg[10];
   end

   // bus sampled on falling edge of its clock
   assign take_bus = bus_en && clk_d_reg && !s2_reg[0];
   // line edge chosen by software; line clock times the line-rail capture and the line bit counter
   assign take_line = !bus_en && (icb0_reg[`ICB0_LINE_FALL_BIT] ?
      (clk_d_reg && !s2_reg[10]) : (!clk_d_reg && s2_reg[10]));

   // expected parity: data alone or with both indicators
   always_comb
   begin
      exp_par = ^s2_reg[8:1];
      if (icb0_reg[`ICB0_COVER_IND_BIT])
         exp_par = exp_par ^ s2_reg[9] ^ s2_reg[10];
      if (icb0_reg[`ICB0_ODD_BIT])
         exp_par = !exp_par;
   end

   // telecom bus capture
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         rx_byte <= 8'h00;
         rx_byte_valid <= 1'b0;
         rx_frame_phase <= 1'b0;
         rx_payload <= 1'b0;
         parity_error <= 1'b0;
      end
      else
      begin
         rx_byte_valid <= take_bus;
         parity_error <= take_bus && (exp_par != s2_reg[11]);
         if (take_bus)
         begin
            rx_byte <= s2_reg[8:1];
            rx_payload <= s2_reg[9];
            rx_frame_phase <= s2_reg[10];
         end
      end
   end

   // line capture: parity pin acts as positive rail
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         rx_line_bits <= 2'b00;
         rx_line_valid <= 1'b0;
      end
      else
      begin
         rx_line_valid <= take_line;
         if (take_line)
            rx_line_bits <= {s2_reg[12] & icb0_reg[`ICB0_DUAL_RAIL_BIT],
               s2_reg[11]};
      end
   end

   // sticky error: a new error wins over the clearing read
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         parity_err_sticky_reg <= 1'b0;
      else if (take_bus && exp_par != s2_reg[11])
         parity_err_sticky_reg <= 1'b1;
      else if (rd_en && addr == `PORT_STATUS_OFFSET)
         parity_err_sticky_reg <= 1'b0;
   end

   // line bit counter, status only; wraps freely
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         line_bit_cnt_reg <= 8'h00;
      else if (take_line)
         line_bit_cnt_reg <= line_bit_cnt_reg + 8'h01;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         rd_data <= 8'h00;
      else if (rd_en && addr == `ICB0_OFFSET)
         rd_data <= icb0_reg;
      else if (rd_en && addr == `PORT_STATUS_OFFSET)
         rd_data <= {line_bit_cnt_reg[5:0], bus_en, parity_err_sticky_reg};
      else
         rd_data <= 8'h00;
   end
endmodule : trib_ingress_port
`default_nettype wire

// *** hw/trib_ingress_source.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "trib_ingress_cfg.svh"
module trib_ingress_source
(
   input wire logic ref_clk,
   input wire logic rst_n,
   trib_ingress_if.source link,
   input wire logic bus_mode,
   input wire logic parity_odd,
   input wire logic parity_cover_ind,
   input wire logic dual_rail,
   input wire logic [7:0] byte_in,
   input wire logic byte_is_overhead,
   input wire logic byte_is_c1j0,
   input wire logic byte_is_j1,
   input wire logic line_pos_in,
   input wire logic line_neg_in,
   output logic byte_taken
);
   trib_ingress_pkg::src_state_e state_reg;
   logic [7:0] div_reg;
   logic clk_reg;
   logic par;

   // slow clock from divider; data changes one cycle before the bus clock rises, stable at fall
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         div_reg <= 8'h00;
         clk_reg <= 1'b0;
      end
      else if (div_reg == `LINE_CLK_DIV - 8'h01)
      begin
         div_reg <= 8'h00;
         clk_reg <= !clk_reg;
      end
      else
         div_reg <= div_reg + 8'h01;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         state_reg <= trib_ingress_pkg::src_idle;
      else
      begin
         case (state_reg)
            trib_ingress_pkg::src_idle:
               state_reg <= bus_mode ? trib_ingress_pkg::src_bus :
                  trib_ingress_pkg::src_line;
            trib_ingress_pkg::src_bus:
               if (!bus_mode)
                  state_reg <= trib_ingress_pkg::src_line;
            trib_ingress_pkg::src_line:
               if (bus_mode)
                  state_reg <= trib_ingress_pkg::src_bus;
            default:
               state_reg <= trib_ingress_pkg::src_idle;
         endcase
      end
   end

   wire logic tick = (div_reg == `LINE_CLK_DIV - 8'h01) && !clk_reg;
   wire logic fp = byte_is_c1j0 | byte_is_j1;
   always_comb
   begin
      par = ^byte_in;
      if (parity_cover_ind)
         par = par ^ !byte_is_overhead ^ fp;
      if (parity_odd)
         par = !par;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         link.tx_bus_clock <= 1'b0;
         link.tx_bus_byte_in <= 8'h00;
         link.tx_bus_payload_ind <= 1'b1;
         link.tx_bus_frame_phase_ind <= 1'b0;
         link.tx_bus_parity_in <= 1'b0;
         link.rx_line_neg_data <= 1'b0;
         byte_taken <= 1'b0;
      end
      else
      begin
         byte_taken <= tick && state_reg != trib_ingress_pkg::src_idle;
         if (state_reg == trib_ingress_pkg::src_bus)
         begin
            link.tx_bus_clock <= clk_reg;
            link.rx_line_neg_data <= 1'b0;
            if (tick)
            begin
               link.tx_bus_byte_in <= byte_in;
               link.tx_bus_payload_ind <= !byte_is_overhead;
               link.tx_bus_frame_phase_ind <= fp;
               link.tx_bus_parity_in <= par;
            end
         end
         else if (state_reg == trib_ingress_pkg::src_line)
         begin
            // recovered clock on the indicator pin
            link.tx_bus_frame_phase_ind <= clk_reg;
            if (tick)
            begin
               link.tx_bus_parity_in <= dual_rail ? (line_pos_in & !line_neg_in) :
                  line_pos_in;
               link.rx_line_neg_data <= dual_rail & line_neg_in;
            end
         end
      end
   end
endmodule : trib_ingress_source
`default_nettype wire

// *** test/trib_ingress_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module trib_ingress_monitor
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic bus_mode,
   input wire logic parity_odd,
   input wire logic parity_cover_ind,
   input wire logic dual_rail,
   input wire logic tx_bus_clock,
   input wire logic [7:0] tx_bus_byte_in,
   input wire logic tx_bus_payload_ind,
   input wire logic tx_bus_frame_phase_ind,
   input wire logic tx_bus_parity_in,
   input wire logic rx_line_neg_data
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic fp;
   logic exp_par;
   assign fp = tx_bus_frame_phase_ind;
   // indicator terms only count when coverage is on
   assign exp_par = ^tx_bus_byte_in ^ parity_odd ^ (parity_cover_ind & (tx_bus_payload_ind ^ fp));
   property p_par_byte;
      bus_mode && !parity_cover_ind && $fell(tx_bus_clock) |-> tx_bus_parity_in == exp_par;
   endproperty
   a_par_byte: assert property (p_par_byte)
      else $error("parity over byte wrong");
   property p_par_cover;
      bus_mode && parity_cover_ind && $fell(tx_bus_clock) |-> tx_bus_parity_in == exp_par;
   endproperty
   a_par_cover: assert property (p_par_cover)
      else $error("parity over byte and indicators wrong");
   property p_bclk_high;
      bus_mode && $rose(tx_bus_clock) |-> tx_bus_clock[*4] ##1 !tx_bus_clock;
   endproperty
   a_bclk_high: assert property (p_bclk_high)
      else $error("bus clock high phase not 4 cycles");
   property p_bclk_low;
      bus_mode && $fell(tx_bus_clock) |-> !tx_bus_clock[*4] ##1 tx_bus_clock;
   endproperty
   a_bclk_low: assert property (p_bclk_low)
      else $error("bus clock low phase not 4 cycles");
   property p_hold;
      bus_mode && $fell(tx_bus_clock)
         |-> $stable({tx_bus_byte_in, tx_bus_payload_ind, fp, tx_bus_parity_in})[*3];
   endproperty
   a_hold: assert property (p_hold)
      else $error("bus lines moved after sampling edge");
   property p_lclk;
      !bus_mode && $rose(fp) |-> fp[*4] ##1 !fp;
   endproperty
   a_lclk: assert property (p_lclk)
      else $error("line clock high phase not 4 cycles");
   property p_pos;
      !bus_mode && $rose(fp) |-> $stable(tx_bus_parity_in) ##1 $stable(tx_bus_parity_in);
   endproperty
   a_pos: assert property (p_pos)
      else $error("positive rail moved at line clock rise");
   property p_neg;
      !bus_mode && dual_rail && $rose(fp) |-> $stable(rx_line_neg_data)[*2];
   endproperty
   a_neg: assert property (p_neg)
      else $error("negative rail moved at line clock rise");
   c_marker: cover property (bus_mode && $fell(tx_bus_clock) && fp);
   c_cover: cover property (bus_mode && parity_cover_ind && $fell(tx_bus_clock));
   c_line: cover property (!bus_mode && $rose(fp));
endmodule : trib_ingress_monitor
`default_nettype wire

// *** test/tributary_ingress_input_port_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module tributary_ingress_input_port_bench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wr_data = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic bus_mode = 1'b1;
   logic parity_odd = 1'b0;
   logic parity_cover_ind = 1'b0;
   logic dual_rail = 1'b1;
   logic [7:0] byte_in = 8'h00;
   logic byte_is_overhead = 1'b0;
   logic byte_is_c1j0 = 1'b0;
   logic byte_is_j1 = 1'b0;
   logic line_pos_in = 1'b0;
   logic line_neg_in = 1'b0;
   logic byte_taken;
   logic [7:0] rd_data;
   logic [7:0] rx_byte;
   logic rx_byte_valid;
   logic rx_frame_phase;
   logic rx_payload;
   logic parity_error;
   logic [1:0] rx_line_bits;
   logic rx_line_valid;
   int mismatches = 0;
   int compares = 0;
   // {byte, overhead, c1j0, j1, want phase, want payload}
   logic [12:0] rows [4] = '{13'h14B0, 13'h1ECB, 13'h0027, 13'h1FE1};
   always #12.5 ref_clk = ~ref_clk;
   trib_ingress_if link_if ();
   trib_ingress_source trib_ingress_source_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .link(link_if), .bus_mode(bus_mode), .parity_odd(parity_odd),
      .parity_cover_ind(parity_cover_ind), .dual_rail(dual_rail), .byte_in(byte_in),
      .byte_is_overhead(byte_is_overhead), .byte_is_c1j0(byte_is_c1j0),
      .byte_is_j1(byte_is_j1), .line_pos_in(line_pos_in), .line_neg_in(line_neg_in),
      .byte_taken(byte_taken));
   trib_ingress_port trib_ingress_port_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link_if),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .rx_frame_phase(rx_frame_phase),
      .rx_payload(rx_payload), .parity_error(parity_error), .rx_line_bits(rx_line_bits),
      .rx_line_valid(rx_line_valid));
   trib_ingress_monitor trib_ingress_monitor_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .bus_mode(bus_mode), .parity_odd(parity_odd), .parity_cover_ind(parity_cover_ind),
      .dual_rail(dual_rail), .tx_bus_clock(link_if.tx_bus_clock),
      .tx_bus_byte_in(link_if.tx_bus_byte_in), .tx_bus_payload_ind(link_if.tx_bus_payload_ind),
      .tx_bus_frame_phase_ind(link_if.tx_bus_frame_phase_ind),
      .tx_bus_parity_in(link_if.tx_bus_parity_in), .rx_line_neg_data(link_if.rx_line_neg_data));
   task automatic test_done();
      if (mismatches == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      compares++;
      if (seen !== want)
      begin
         mismatches++;
         $display("[FAIL] %0t seen %0h want %0h", $time, seen, want);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] want);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      @(posedge ref_clk);
      check(rd_data, want);
   endtask : rd
   // three pulses so the last one surely carries the newly held inputs
   task automatic wait3(ref logic s);
      int n;
      for (int k = 0; k < 3; k++)
      begin
         n = 0;
         do
         begin
            @(posedge ref_clk);
            n++;
         end
         while (s !== 1'b1 && n < 40);
         if (n >= 40)
            mismatches++;
      end
   endtask : wait3
   // mode change only under reset so both ends agree from the first edge
   task automatic setup(input logic [7:0] icb, input logic odd_src);
      rst_n <= 1'b0;
      bus_mode <= icb[2];
      parity_odd <= odd_src;
      parity_cover_ind <= icb[1];
      repeat (4) @(posedge ref_clk);
      check({byte_taken, rx_byte_valid, rx_line_valid, parity_error}, 8'h00);
      rst_n <= 1'b1;
      wr(12'h13B, icb);
   endtask : setup
   initial
   begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(12'h13B, 8'h00);
      for (int c = 0; c < 5; c++)
      begin
         setup({5'h01, c[1], c[0] | c[2]}, c[0]);
         foreach (rows[i])
         begin
            byte_in <= rows[i][12:5];
            byte_is_overhead <= rows[i][4];
            byte_is_c1j0 <= rows[i][3];
            byte_is_j1 <= rows[i][2];
            wait3(rx_byte_valid);
            check(rx_byte, rows[i][12:5]);
            check({rx_frame_phase, rx_payload, parity_error}, {rows[i][1:0], c[2]});
         end
      end
      // sense now matches the source, so no new error can refill the sticky bit
      wr(12'h13B, 8'h04);
      rd(12'h13C, 8'h03);
      rd(12'h13C, 8'h02);
      wr(12'h100, 8'hFF);
      rd(12'h13B, 8'h04);
      rd(12'h100, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         if (c[1:0] == 2'b00)
            setup({3'h0, 1'b1, c[2], 3'h0}, 1'b0);
         line_pos_in <= c[0];
         line_neg_in <= c[1];
         wait3(rx_line_valid);
         // dual rail: a bit on both rails leaves the positive rail low
         check({rx_byte_valid, rx_line_bits}, {1'b0, c[1], c[0] & ~c[1]});
      end
      test_done();
   end
   initial
   begin
      #500000;
      mismatches++;
      test_done();
   end
endmodule : tributary_ingress_input_port_bench
`default_nettype wire
